// >>> dv/arsp_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module arsp_assertions (
   input wire logic clk_i,          // Master clock
   input wire logic reset_i,        // Sync reset
   input wire logic write_active_o, // Write window
   input wire logic cs_n,           // Select
   input wire logic sclk,           // Shift clock
   input wire logic dout_d,         // Data driven
   input wire logic dout_oe,        // Data enable
   input wire logic result_ready_n  // Ready, active low
);
   logic [5:0] rise_cnt;

   default clocking @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   // Shift clocks seen within one select
   always_ff @(posedge clk_i) begin
      if (reset_i || cs_n) begin
         rise_cnt <= 6'h00;
      end else if ($rose(sclk)) begin
         rise_cnt <= rise_cnt + 6'h01;
      end
   end

   oe_select_a: assert property (dout_oe == !cs_n)
      else $error("data enable does not follow select");
   write_len_a: assert property ($rose(write_active_o) |->
      write_active_o [*5] ##1 !write_active_o)
      else $error("write window not five cycles");
   write_ready_a: assert property (write_active_o |-> result_ready_n)
      else $error("ready low during write");
   tied_pulse_a: assert property ($fell(write_active_o) && !cs_n |->
      ##[0:1] !result_ready_n [*5] ##[1:2] result_ready_n)
      else $error("ready pulse wrong with select low");
   held_high_a: assert property ($fell(write_active_o) && cs_n |->
      result_ready_n [*6] ##[1:2] !result_ready_n)
      else $error("ready high time wrong with select high");
   sel_release_a: assert property ($fell(cs_n) && !result_ready_n |->
      !result_ready_n [*2] ##[1:12] result_ready_n)
      else $error("ready not released after select");
   sel_on_low_a: assert property ($fell(cs_n) && !result_ready_n |-> !sclk)
      else $error("select fell with shift clock high");
   sclk_half_a: assert property ($changed(sclk) |=> $stable(sclk))
      else $error("shift clock too fast");
   data_steady_a: assert property ($rose(sclk) && !cs_n && !$past(cs_n)
      && !write_active_o |-> $stable(dout_d))
      else $error("data moved at rising shift edge");
   bit_count_a: assert property ($rose(cs_n) |->
      rise_cnt == 6'h14 || rise_cnt == 6'h18)
      else $error("read length not 20 or 24");
   no_shift_write_a: assert property (write_active_o && !cs_n |-> !$fell(sclk))
      else $error("shift during write window");
endmodule
`default_nettype wire

// >>> dv/tb_adc_serial_readout_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_serial_readout_port;
   logic clk_i;
   logic reset_i;
   logic [19:0] result_i;
   logic result_valid_i;
   logic write_active;
   arsp_pkg::arsp_mode_t mode;
   logic len24;
   logic [23:0] data;
   logic data_valid;
   logic data_settled;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [19:0] codes [6] = '{20'h7_ffff, 20'h0_0000, 20'h8_0000,
      20'h1_2345, 20'hf_edcb, 20'h0_0001};

   arsp_link_if lk();
   // Second device read by the bench itself, any length
   arsp_link_if lk2();

   arsp_device u_arsp_device (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .result_i(result_i),
      .result_valid_i(result_valid_i),
      .write_active_o(write_active),
      .link(lk)
   );
   arsp_device u_arsp_device_b (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .result_i(result_i),
      .result_valid_i(result_valid_i),
      .write_active_o(),
      .link(lk2)
   );
   arsp_host u_arsp_host (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .mode_i(mode),
      .len24_i(len24),
      .data_o(data),
      .data_valid_o(data_valid),
      .data_settled_o(data_settled),
      .link(lk)
   );
   arsp_assertions u_arsp_assertions (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .write_active_o(write_active),
      .cs_n(lk.cs_n),
      .sclk(lk.sclk),
      .dout_d(lk.dout_d),
      .dout_oe(lk.dout_oe),
      .result_ready_n(lk.result_ready_n)
   );

   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input bit ok, input string msg);
      tests_run++;
      if (!ok) begin
         err_total++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic tick();
      @(posedge clk_i);
      #2;
   endtask

   // Pulses during reset clock the second device's link-side reset
   task automatic do_reset();
      for (int i = 0; i < 30; i++) begin
         tick();
         reset_i = (i < 15);
         lk2.sclk = 1'b1;
         #15;
         lk2.sclk = 1'b0;
      end
   endtask

   task automatic send(input logic [19:0] r);
      result_i = r;
      result_valid_i = 1'b1;
      tick();
      result_valid_i = 1'b0;
   endtask

   task automatic wait_word(input logic [19:0] r);
      int n;
      n = 0;
      while (data_valid !== 1'b1 && n < 600) begin
         tick();
         n++;
      end
      chk(data === {r, 4'h0}, "host word");
   endtask

   // Shift clock only runs inside the frame
   task automatic rd2(input int nbits, input logic [19:0] r);
      logic [23:0] w;
      w = {r, 4'h0};
      lk2.cs_n = 1'b0;
      #10;
      for (int i = 0; i < nbits; i++) begin
         chk(lk2.dout_line === w[23-i], "bit");
         lk2.sclk = 1'b1;
         #15;
         lk2.sclk = 1'b0;
         #15;
      end
      lk2.cs_n = 1'b1;
      #10;
      chk(lk2.dout_oe === 1'b0, "pin not released");
      tick();
   endtask

   task automatic sc_codes();
      for (int i = 0; i < 6; i++) begin
         len24 = i[0];
         send(codes[i]);
         wait_word(codes[i]);
         chk(data_settled === (i == 5), "settled flag");
      end
   endtask

   task automatic sc_partial();
      rd2(16, codes[5]);
      send(20'h5_a5a5);
      wait_word(20'h5_a5a5);
      rd2(24, 20'h5_a5a5);
   endtask

   task automatic sc_held_high();
      mode = arsp_pkg::ARSP_HELD_HIGH;
      send(20'h3_c3c3);
      repeat (2) tick();
      chk(lk.result_ready_n === 1'b1 && write_active === 1'b1, "write");
      repeat (20) tick();
      chk(lk.result_ready_n === 1'b0, "ready idle");
      chk(lk.dout_oe === 1'b0 && data_valid === 1'b0, "read seen");
   endtask

   task automatic sc_free_run();
      mode = arsp_pkg::ARSP_FREE_RUN;
      send(20'ha_0c35);
      wait_word(20'ha_0c35);
   endtask

   task automatic sc_tied_low();
      mode = arsp_pkg::ARSP_TIED_LOW;
      repeat (4) tick();
      chk(lk.dout_oe === 1'b1, "pin not driven");
      send(20'h9_6e01);
      wait_word(20'h9_6e01);
      repeat (4) tick();
      chk(lk.dout_line === 1'b0, "last bit lost");
      send(20'h4_0002);
      wait_word(20'h4_0002);
   endtask

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // Whole run needs a few thousand cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end

   initial begin
      reset_i = 1'b1;
      result_i = 20'h0_0000;
      result_valid_i = 1'b0;
      mode = arsp_pkg::ARSP_GATED;
      len24 = 1'b0;
      lk2.cs_n = 1'b1;
      lk2.sclk = 1'b0;
      do_reset();
      sc_codes();
      sc_partial();
      sc_held_high();
      sc_free_run();
      sc_tied_low();
      close_out();
   end
endmodule
`default_nettype wire

// >>> hw/arsp_device.sv
// How it works
// - Data pin floats while select high
// - Select tied low: write, then low pulse
// - Per-read select: ready low until select
// - Select held high: ready high around write
// - Writes never wait for reads
// - Host flags first five results as not settled
// - Twenty-bit two's complement, MSB first
// - Bit pointer returns to MSB each ready
// - Extra shift clocks shift out zeros
// - Shift clock at most 9.6 MHz
// - Host finishes reading before next ready
// - Select low presents MSB at once
// - Next bit appears after falling edge
// - Free-run clock: select on falling edge
// - Tied-low select keeps pin driven, zero after last bit
// - Data pin tristated outside reads unless select tied low
// - Write phase five cycles, low and high phases six
`timescale 1ns/1ps
`default_nettype none
module arsp_device (
   input wire logic clk_i,                               // Master clock
   input wire logic reset_i,                             // Sync reset
   input wire logic [arsp_pkg::RESULT_W-1:0] result_i,   // New result
   input wire logic result_valid_i,                      // Result strobe
   output logic write_active_o,                          // Write window
   arsp_link_if.dev link                                 // Serial link
);
   arsp_pkg::arsp_dev_state_t state;
   logic [arsp_pkg::RESULT_W-1:0] result_shift_reg;
   logic [arsp_pkg::RESULT_W-1:0] pend;
   logic [arsp_pkg::RESULT_W-1:0] wr_data;
   logic pend_valid;
   logic [2:0] wr_cnt;
   logic [2:0] tcnt;
   logic ready_n;
   logic [arsp_pkg::PTR_W-1:0] base;
   logic start_write;
   logic last_write;

   // Link domain
   logic link_rst;
   logic [arsp_pkg::PTR_W-1:0] fall_cnt;
   logic [arsp_pkg::PTR_W-1:0] next_fall_cnt;
   logic [arsp_pkg::PTR_W-1:0] fall_gray;
   logic [arsp_pkg::PTR_W-1:0] fall_gray_s;
   logic [arsp_pkg::PTR_W-1:0] fall_cnt_s;
   logic [arsp_pkg::PTR_W-1:0] bit_idx;
   logic cs_n_s;
   logic sel_at_rise;

   arsp_sync #(.W(1)) u_link_rst (
      .clk_i(link.sclk),
      .d_i(reset_i),
      .q_o(link_rst)
   );

   arsp_sync #(.W(1)) u_sel (
      .clk_i(clk_i),
      .d_i(link.cs_n),
      .q_o(cs_n_s)
   );

   arsp_sync #(.W(arsp_pkg::PTR_W)) u_ptr (
      .clk_i(clk_i),
      .d_i(fall_gray),
      .q_o(fall_gray_s)
   );

   assign next_fall_cnt = fall_cnt + 1'b1;

   // Select on falling edge
   // A fall that coincides with select going low must not skip the MSB
   always_ff @(posedge link.sclk) begin
      if (link_rst) begin
         sel_at_rise <= 1'b0;
      end else begin
         sel_at_rise <= !link.cs_n;
      end
   end

   // Count falling edges
   // Counted only while selected, so a free-running clock is harmless
   always_ff @(negedge link.sclk) begin
      if (link_rst) begin
         fall_cnt <= '0;
         fall_gray <= '0;
      end else if (!link.cs_n && sel_at_rise) begin
         fall_cnt <= next_fall_cnt;
         fall_gray <= arsp_pkg::bin2gray(next_fall_cnt);
      end
   end

   assign fall_cnt_s = arsp_pkg::gray2bin(fall_gray_s);

   // Pointer relative to base
   // Base only moves inside the write window, when no read is allowed,
   // so the link side may read it without a handshake
   assign bit_idx = fall_cnt - base;

   always_comb begin
      if (bit_idx < arsp_pkg::PTR_W'(arsp_pkg::RESULT_W)) begin
         link.dout_d = result_shift_reg[5'(arsp_pkg::RESULT_W - 1)
            - bit_idx[4:0]];
      end else begin
         link.dout_d = 1'b0;
      end
   end

   assign link.dout_oe = ~link.cs_n;

   assign link.result_ready_n = ready_n;

   assign start_write = pend_valid
      && (state == arsp_pkg::ARSP_IDLE
      || state == arsp_pkg::ARSP_WAIT_SEL);
   assign last_write = wr_cnt == 3'(arsp_pkg::WRITE_CYC - 1);

   // Newest result wins; a strobe in the take cycle is kept
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pend_valid <= 1'b0;
         pend <= arsp_pkg::RESULT_RESET;
      end else if (result_valid_i) begin
         pend_valid <= 1'b1;
         pend <= result_i;
      end else if (start_write) begin
         pend_valid <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         result_shift_reg <= arsp_pkg::RESULT_RESET;
      end else if (state == arsp_pkg::ARSP_WRITE) begin
         result_shift_reg[(arsp_pkg::RESULT_W - 1)
            - arsp_pkg::CHUNK_W * int'(wr_cnt) -: arsp_pkg::CHUNK_W]
            <= wr_data[(arsp_pkg::RESULT_W - 1)
            - arsp_pkg::CHUNK_W * int'(wr_cnt) -: arsp_pkg::CHUNK_W];
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         write_active_o <= 1'b0;
      end else begin
         write_active_o <= start_write
            || (state == arsp_pkg::ARSP_WRITE && !last_write);
      end
   end

   // Device cannot tell per-read from held-high select while select
   // is high, so both share one sequence: ready rises for the write,
   // stays high for the high time, then waits low for a select.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= arsp_pkg::ARSP_IDLE;
         ready_n <= 1'b1;
         wr_cnt <= '0;
         tcnt <= '0;
         wr_data <= arsp_pkg::RESULT_RESET;
         base <= '0;
      end else begin
         unique case (state)
            arsp_pkg::ARSP_IDLE,
            arsp_pkg::ARSP_WAIT_SEL: begin
               if (start_write) begin
                  ready_n <= 1'b1;
                  wr_cnt <= '0;
                  wr_data <= pend;
                  state <= arsp_pkg::ARSP_WRITE;
               end else if (state == arsp_pkg::ARSP_WAIT_SEL
                            && !cs_n_s) begin
                  tcnt <= '0;
                  state <= arsp_pkg::ARSP_LOW;
               end
            end
            arsp_pkg::ARSP_WRITE: begin
               wr_cnt <= wr_cnt + 1'b1;
               if (last_write) begin
                  base <= fall_cnt_s;
                  tcnt <= '0;
                  if (!cs_n_s) begin
                     ready_n <= 1'b0;
                     state <= arsp_pkg::ARSP_LOW;
                  end else begin
                     state <= arsp_pkg::ARSP_HIGH;
                  end
               end
            end
            arsp_pkg::ARSP_HIGH: begin
               tcnt <= tcnt + 1'b1;
               if (tcnt == 3'(arsp_pkg::HIGH_CYC - 1)) begin
                  ready_n <= 1'b0;
                  state <= arsp_pkg::ARSP_WAIT_SEL;
               end
            end
            arsp_pkg::ARSP_LOW: begin
               tcnt <= tcnt + 1'b1;
               if (tcnt == 3'(arsp_pkg::LOW_CYC - 1)) begin
                  ready_n <= 1'b1;
                  state <= arsp_pkg::ARSP_IDLE;
               end
            end
            default: begin
               state <= arsp_pkg::ARSP_IDLE;
               ready_n <= 1'b1;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> hw/arsp_host.sv
`timescale 1ns/1ps
`default_nettype none
module arsp_host (
   input wire logic clk_i,                           // Host clock
   input wire logic reset_i,                         // Sync reset
   input wire arsp_pkg::arsp_mode_t mode_i,          // Select usage
   input wire logic len24_i,                         // 24-bit reads
   output logic [arsp_pkg::LONG_W-1:0] data_o,       // Read word
   output logic data_valid_o,                        // Word strobe
   output logic data_settled_o,                      // Filter settled
   arsp_link_if.host link                            // Serial link
);
   arsp_pkg::arsp_host_state_t state;
   logic [1:0] hcnt;
   logic tick;
   logic sclk;
   logic cs_n;
   logic run;
   logic [3:0] boot_left;
   logic rdy_s;
   logic dout_s;
   logic rdy_q;
   logic pending;
   logic [2:0] conv_cnt;
   logic [4:0] bits;
   logic len24;
   logic [arsp_pkg::LONG_W-1:0] shreg;

   arsp_sync #(.W(2)) u_in (
      .clk_i(clk_i),
      .d_i({link.result_ready_n, link.dout_line}),
      .q_o({rdy_s, dout_s})
   );

   assign link.sclk = sclk;
   assign link.cs_n = cs_n;
   assign tick = hcnt == 2'(arsp_pkg::SCLK_HALF_CYC - 1);
   // Clock also runs in reset and briefly after, to reset the far end
   assign run = reset_i || boot_left != '0
      || mode_i == arsp_pkg::ARSP_FREE_RUN
      || state == arsp_pkg::ARSP_H_SHIFT;

   // Divided shift clock
   // Written so that an unknown start value settles in one cycle
   always_ff @(posedge clk_i) begin
      if (hcnt < 2'(arsp_pkg::SCLK_HALF_CYC - 1)) begin
         hcnt <= hcnt + 1'b1;
      end else begin
         hcnt <= '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (tick) begin
         if (run && !sclk) begin
            sclk <= 1'b1;
         end else begin
            sclk <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         boot_left <= 4'(arsp_pkg::BOOT_TICKS);
      end else if (tick && boot_left != '0) begin
         boot_left <= boot_left - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdy_q <= 1'b1;
         conv_cnt <= '0;
      end else begin
         rdy_q <= rdy_s;
         if (rdy_q && !rdy_s
             && conv_cnt != 3'(arsp_pkg::SETTLE_CONV)) begin
            conv_cnt <= conv_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= arsp_pkg::ARSP_H_IDLE;
         cs_n <= 1'b1;
         pending <= 1'b0;
         bits <= '0;
         len24 <= 1'b0;
         shreg <= '0;
         data_o <= '0;
         data_valid_o <= 1'b0;
         data_settled_o <= 1'b0;
      end else begin
         data_valid_o <= 1'b0;
         if (rdy_q && !rdy_s && mode_i != arsp_pkg::ARSP_HELD_HIGH) begin
            pending <= 1'b1;
         end
         unique case (state)
            arsp_pkg::ARSP_H_IDLE: begin
               cs_n <= mode_i != arsp_pkg::ARSP_TIED_LOW;
               if (pending && tick && !(run && !sclk)) begin
                  cs_n <= 1'b0;
                  bits <= '0;
                  len24 <= len24_i;
                  state <= arsp_pkg::ARSP_H_SHIFT;
                  if (!(rdy_q && !rdy_s)) begin
                     pending <= 1'b0;
                  end
               end
            end
            arsp_pkg::ARSP_H_SHIFT: begin
               if (tick && !sclk) begin
                  shreg <= {shreg[arsp_pkg::LONG_W-2:0], dout_s};
                  bits <= bits + 1'b1;
               end else if (tick && sclk && bits
                            == (len24 ? 5'(arsp_pkg::LONG_W)
                                : 5'(arsp_pkg::RESULT_W))) begin
                  // Stop after 20 or 24 clocks
                  cs_n <= mode_i != arsp_pkg::ARSP_TIED_LOW;
                  data_o <= len24 ? shreg
                     : {shreg[arsp_pkg::RESULT_W-1:0], 4'h0};
                  data_valid_o <= 1'b1;
                  data_settled_o <= conv_cnt == 3'(arsp_pkg::SETTLE_CONV);
                  state <= arsp_pkg::ARSP_H_IDLE;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> hw/arsp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface arsp_link_if;
   logic cs_n;
   logic sclk;
   logic dout_d;
   logic dout_oe;
   logic result_ready_n;
   wire dout_line;

   // Released line shows the inverse bit, so a stray sample is caught
   assign dout_line = dout_oe ? dout_d : ~dout_d;

   modport dev(
      input cs_n,
      input sclk,
      output dout_d,
      output dout_oe,
      output result_ready_n
   );
   modport host(
      output cs_n,
      output sclk,
      input dout_line,
      input result_ready_n
   );
endinterface
`default_nettype wire

// >>> hw/arsp_pkg.sv
`default_nettype none
package arsp_pkg;
   // Result word and host transfer lengths
   localparam int RESULT_W = 20;
   localparam int LONG_W = 24;
   localparam int PTR_W = 6;
   // Result write: four bits per master cycle, MSB chunk first
   localparam int CHUNK_W = 4;
   localparam int WRITE_CYC = RESULT_W / CHUNK_W;
   localparam int LOW_CYC = 6;
   localparam int HIGH_CYC = 6;
   localparam logic [19:0] RESULT_RESET = 20'h0_0000;
   localparam logic [19:0] CODE_POS_FULL = 20'h7_ffff;
   localparam logic [19:0] CODE_NEG_FULL = 20'h8_0000;
   // Host shift clock
   localparam int CLK_HZ = 20_000_000;
   localparam int SCLK_MAX_HZ = 9_600_000;
   localparam int SCLK_HALF_MIN =
      (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   // One extra cycle so the two-flop data sampler sees a settled bit
   localparam int SCLK_HALF_CYC = SCLK_HALF_MIN + 1;
   localparam int BOOT_TICKS = 8;
   localparam int SETTLE_CONV = 6;

   typedef enum logic [2:0] {
      ARSP_IDLE, ARSP_WRITE, ARSP_HIGH, ARSP_WAIT_SEL, ARSP_LOW
   } arsp_dev_state_t;

   typedef enum logic {
      ARSP_H_IDLE, ARSP_H_SHIFT
   } arsp_host_state_t;

   typedef enum logic [1:0] {
      ARSP_GATED, ARSP_FREE_RUN, ARSP_TIED_LOW, ARSP_HELD_HIGH
   } arsp_mode_t;

   function automatic logic [PTR_W-1:0] bin2gray(logic [PTR_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [PTR_W-1:0] gray2bin(logic [PTR_W-1:0] g);
      logic [PTR_W-1:0] b;
      b = '0;
      for (int i = PTR_W - 1; i >= 0; i--) begin
         b[i] = g[i] ^ ((i == PTR_W - 1) ? 1'b0 : b[i+1]);
      end
      return b;
   endfunction
endpackage
`default_nettype wire

// >>> hw/arsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module arsp_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,          // Destination clock
   input wire logic [W-1:0] d_i,    // Asynchronous input
   output logic [W-1:0] q_o         // Synchronised output
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i) begin
      meta <= d_i;
      q_o <= meta;
   end
endmodule
`default_nettype wire
